/* File: sbp_port.sv */
// Six-bit general purpose port with open-drain control and serial sharing
`timescale 1ns/1ns
`default_nettype none

module sbp_port #(
  parameter int unsigned PINS = sbp_pkg::PIN_COUNT
) (
  // Clock and resets
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic manual_rst_in,
  input wire logic hw_standby_in,
  input wire logic sw_standby_in,
  // Register port
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Serial channel 0 and 1 controls
  input wire logic serial_init_in,
  input wire logic serial0_transmit_en_in,
  input wire logic serial0_transmit_in,
  input wire logic serial0_receive_enable_in,
  output logic serial0_receive_out,
  input wire logic serial0_clock_oe_in,
  input wire logic serial0_clock_in,
  output logic serial0_clock_out,
  input wire logic serial1_transmit_en_in,
  input wire logic serial1_transmit_in,
  input wire logic serial1_receive_enable_in,
  output logic serial1_receive_out,
  input wire logic serial1_clock_oe_in,
  input wire logic serial1_clock_in,
  output logic serial1_clock_out,
  // External interrupt outputs
  output logic ext_interrupt_4_out,
  output logic ext_interrupt_5_out,
  // Pins
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe_out
);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [5:0] dir_q, dir_d;
  logic [5:0] dout_q, dout_d;
  logic [5:0] odr_q, odr_d;
  logic [7:0] rdata_q, rdata_d;
  logic [5:0] s1_q, s2_q, s3_q;
  logic [5:0] pin_lvl_q, pin_lvl_d;
  logic [5:0] pout_q, pout_d;
  logic [5:0] poe_q, poe_d;
  logic [5:0] fn_oe, fn_val, fn_sel;
  logic clear_all;
  logic hold_lvl;

  // Power-on reset and hardware standby clear; manual reset and software standby keep
  assign clear_all = sys_rst_in | hw_standby_in;
  assign hold_lvl = manual_rst_in | sw_standby_in;

  // Register write decode
  always_comb begin
    dir_d = dir_q;
    dout_d = dout_q;
    odr_d = odr_q;
    if (reg_wr_in && !hold_lvl) begin
      // Only bits 5..0 are stored so reserved bits cannot be modified
      case (reg_addr_in)
        sbp_pkg::ADDR_PIN_DIRECTION: dir_d = reg_wdata_in[5:0];
        sbp_pkg::ADDR_OUTPUT_DATA: dout_d = reg_wdata_in[5:0];
        sbp_pkg::ADDR_OPEN_DRAIN_CONTROL: odr_d = reg_wdata_in[5:0];
        default: begin
          // Writes to pin-level readback land here and are dropped
          dir_d = dir_q;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (clear_all) begin
      dir_q <= sbp_pkg::PORT_RESET_VALUE;
      dout_q <= sbp_pkg::PORT_RESET_VALUE;
      odr_q <= sbp_pkg::PORT_RESET_VALUE;
    end else begin
      dir_q <= dir_d;
      dout_q <= dout_d;
      odr_q <= odr_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin synchroniser, three stages, change accepted when stages two and three agree
  // ---------------------------------------------------------------------------
  always_comb begin
    pin_lvl_d = pin_lvl_q;
    for (int unsigned i = 0; i < PINS; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        pin_lvl_d[i] = s3_q[i];
      end
    end
    // Manual reset and software standby freeze the readback view
    if (hold_lvl) begin
      pin_lvl_d = pin_lvl_q;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    s1_q <= pin_in;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (sys_rst_in) begin
      pin_lvl_q <= sbp_pkg::PORT_RESET_VALUE;
    end else begin
      pin_lvl_q <= pin_lvl_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Shared function selection, identical in every operating mode
  // ---------------------------------------------------------------------------
  always_comb begin
    fn_sel = 6'h00;
    fn_oe = 6'h00;
    fn_val = 6'h00;
    // Serial initialisation hands every pin back to the port registers
    if (!serial_init_in) begin
      fn_sel[sbp_pkg::PIN_TX0] = serial0_transmit_en_in;
      fn_oe[sbp_pkg::PIN_TX0] = serial0_transmit_en_in;
      fn_val[sbp_pkg::PIN_TX0] = serial0_transmit_in;
      fn_sel[sbp_pkg::PIN_TX1] = serial1_transmit_en_in;
      fn_oe[sbp_pkg::PIN_TX1] = serial1_transmit_en_in;
      fn_val[sbp_pkg::PIN_TX1] = serial1_transmit_in;
      fn_sel[sbp_pkg::PIN_RX0] = serial0_receive_enable_in;
      fn_sel[sbp_pkg::PIN_RX1] = serial1_receive_enable_in;
      fn_sel[sbp_pkg::PIN_CLK0] = serial0_clock_oe_in;
      fn_oe[sbp_pkg::PIN_CLK0] = serial0_clock_oe_in;
      fn_val[sbp_pkg::PIN_CLK0] = serial0_clock_in;
      fn_sel[sbp_pkg::PIN_CLK1] = serial1_clock_oe_in;
      fn_oe[sbp_pkg::PIN_CLK1] = serial1_clock_oe_in;
      fn_val[sbp_pkg::PIN_CLK1] = serial1_clock_in;
    end
  end

  // Pin drivers: open drain only ever drives low, letting the pull-up give high
  always_comb begin
    pout_d = 6'h00;
    poe_d = 6'h00;
    for (int unsigned i = 0; i < PINS; i++) begin
      if (fn_sel[i]) begin
        pout_d[i] = fn_val[i];
        poe_d[i] = fn_oe[i] & ~(odr_q[i] & fn_val[i]);
      end else begin
        pout_d[i] = dout_q[i];
        poe_d[i] = dir_q[i] & ~(odr_q[i] & dout_q[i]);
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (clear_all) begin
      pout_q <= sbp_pkg::PORT_RESET_VALUE;
      poe_q <= sbp_pkg::PORT_RESET_VALUE;
    end else begin
      pout_q <= pout_d;
      poe_q <= poe_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Read path, data valid one cycle after the read strobe only
  // ---------------------------------------------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        sbp_pkg::ADDR_PIN_DIRECTION: rdata_d = sbp_pkg::UNDEFINED_READ;
        sbp_pkg::ADDR_OUTPUT_DATA: rdata_d = {sbp_pkg::RESERVED_READ, dout_q};
        sbp_pkg::ADDR_PIN_LEVEL_READBACK:
          rdata_d = {sbp_pkg::RESERVED_READ, (dir_q & dout_q) | (~dir_q & pin_lvl_q)};
        sbp_pkg::ADDR_OPEN_DRAIN_CONTROL: rdata_d = {sbp_pkg::RESERVED_READ, odr_q};
        default: rdata_d = sbp_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // Receive and interrupt outputs take the filtered pin level
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rdata_q <= 8'h00;
      serial0_receive_out <= 1'h1;
      serial1_receive_out <= 1'h1;
      serial0_clock_out <= 1'h0;
      serial1_clock_out <= 1'h0;
      ext_interrupt_4_out <= 1'h1;
      ext_interrupt_5_out <= 1'h1;
    end else begin
      rdata_q <= rdata_d;
      serial0_receive_out <= pin_lvl_d[sbp_pkg::PIN_RX0];
      serial1_receive_out <= pin_lvl_d[sbp_pkg::PIN_RX1];
      serial0_clock_out <= pin_lvl_d[sbp_pkg::PIN_CLK0];
      serial1_clock_out <= pin_lvl_d[sbp_pkg::PIN_CLK1];
      ext_interrupt_4_out <= pin_lvl_d[sbp_pkg::PIN_CLK0];
      ext_interrupt_5_out <= pin_lvl_d[sbp_pkg::PIN_CLK1];
    end
  end

  assign reg_rdata_out = rdata_q;
  assign pin_out = pout_q;
  assign pin_oe_out = poe_q;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_dir_clear;
    @(posedge ref_clk_in) hw_standby_in |=> (dir_q == 6'h00 && dout_q == 6'h00 && odr_q == 6'h00);
  endproperty
  a_dir_clear: assert property (p_dir_clear) else $error("standby did not clear port registers");

  property p_keep_manual;
    @(posedge ref_clk_in) disable iff (sys_rst_in || hw_standby_in)
      manual_rst_in |=> $stable(dout_q) && $stable(dir_q);
  endproperty
  a_keep_manual: assert property (p_keep_manual) else $error("manual reset changed registers");

  property p_dout_rw;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (reg_wr_in && !hold_lvl && !hw_standby_in && reg_addr_in == sbp_pkg::ADDR_OUTPUT_DATA)
      ##1 (reg_rd_in && reg_addr_in == sbp_pkg::ADDR_OUTPUT_DATA && !reg_wr_in && !hw_standby_in)
      |=> reg_rdata_out[5:0] == $past(reg_wdata_in[5:0], 2);
  endproperty
  a_dout_rw: assert property (p_dout_rw) else $error("output data readback mismatch");

  property p_dir_read;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      reg_rd_in && reg_addr_in == sbp_pkg::ADDR_PIN_DIRECTION |=> reg_rdata_out == sbp_pkg::UNDEFINED_READ;
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction register was readable");

  property p_reserved;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      reg_rd_in |=> reg_rdata_out[7:6] == sbp_pkg::RESERVED_READ;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not constant");

  property p_level_read;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      reg_rd_in && reg_addr_in == sbp_pkg::ADDR_PIN_LEVEL_READBACK
      |=> reg_rdata_out[5:0] == (($past(dir_q) & $past(dout_q)) | (~$past(dir_q) & $past(pin_lvl_q)));
  endproperty
  a_level_read: assert property (p_level_read) else $error("pin-level readback wrong");

  property p_output_drive;
    @(posedge ref_clk_in) disable iff (sys_rst_in || hw_standby_in)
      (serial_init_in && dir_q[0] && !odr_q[0]) |=> pin_oe_out[0] && pin_out[0] == $past(dout_q[0]);
  endproperty
  a_output_drive: assert property (p_output_drive) else $error("output pin not driven");

  property p_open_drain;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (odr_q != 6'h00) |=> (pin_oe_out & pin_out & $past(odr_q)) == 6'h00;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain pin driven high");

  property p_rx_input;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (!serial_init_in && serial0_receive_enable_in) |=> !pin_oe_out[sbp_pkg::PIN_RX0];
  endproperty
  a_rx_input: assert property (p_rx_input) else $error("receive pin driven while enabled");

endmodule // sbp_port

`default_nettype wire

/* File: sbp_pkg.sv */
// Package with register map, field layout and reset values of the six-bit port
// -----------------------------------------------------------------------------
// Summary of operation
// -----------------------------------------------------------------------------
// Summary of operation
// - Six two-way pins, 5 down to 0, each usable as general input or output.
// - Pin selection logic is the same in every chip operating mode.
// - Pins also carry serial channel 0/1 signals and external interrupts 4, 5.
// - Direction register is write-only; reading it returns an undefined value.
// - Direction bit 1 makes the pin an output, 0 an input.
// - Port registers clear on power-on reset and hardware standby, else keep.
// - Output data register is read/write and holds the driven output levels.
// - Bits 7 and 6 are reserved: unchanged by writes, undetermined on reads.
// - Pin-level read gives output data where direction is 1, pin where 0.
// - Pin-level view follows pins after reset; holds across manual/soft standby.
// - Open-drain bit 1 disables the high-side driver; 0 gives push-pull.
// - When serial channels are initialised pins fall back to port settings.
// - Receive enable 1 makes the receive pin serial input, ignoring direction.
package sbp_pkg;
  localparam int unsigned PIN_COUNT = 6;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  // Register byte addresses
  localparam logic [15:0] ADDR_PIN_DIRECTION = 16'hfeb2;
  localparam logic [15:0] ADDR_PIN_LEVEL_READBACK = 16'hff52;
  localparam logic [15:0] ADDR_OUTPUT_DATA = 16'hff62;
  localparam logic [15:0] ADDR_OPEN_DRAIN_CONTROL = 16'hff76;
  // Reset value of the implemented bits
  localparam logic [5:0] PORT_RESET_VALUE = 6'h00;
  // Value shown in reserved or undefined read positions
  localparam logic [1:0] RESERVED_READ = 2'h0;
  localparam logic [7:0] UNDEFINED_READ = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Pin assignment of shared functions
  localparam int unsigned PIN_TX0 = 0;
  localparam int unsigned PIN_TX1 = 1;
  localparam int unsigned PIN_RX0 = 2;
  localparam int unsigned PIN_RX1 = 3;
  localparam int unsigned PIN_CLK0 = 4;
  localparam int unsigned PIN_CLK1 = 5;
endpackage

/* File: sbp_pin_model.sv */
// Pin side model: external drivers and pull-ups on the six port pins
`timescale 1ns/1ns
`default_nettype none

module sbp_pin_model (
  // Device side
  input wire logic [5:0] pin_out_in,
  input wire logic [5:0] pin_oe_in,
  // Bench control of outside drivers
  input wire logic [5:0] ext_en_in,
  input wire logic [5:0] ext_val_in,
  // Resolved pin levels
  output logic [5:0] level_out
);
  // Pull-up wins when nobody drives, so an open-drain high reads as 1
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      level_out[i] = pin_oe_in[i] ? pin_out_in[i] : (ext_en_in[i] ? ext_val_in[i] : 1'b1);
    end
  end
endmodule // sbp_pin_model

`default_nettype wire

/* File: tb.sv */
// Self-checking bench of the six-bit port
`timescale 1ns/1ns
`default_nettype none

module tb;
  typedef struct {logic [15:0] a; logic [7:0] w; logic [7:0] e;} sbp_row_s;
  logic clk = 1'h0, rst = 1'h1, mrst = 1'h0, hws = 1'h0, sws = 1'h0, sinit = 1'h1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wd = 8'h00, rdata;
  logic wr = 1'h0, rd = 1'h0;
  logic [1:0] txe = 2'h0, tx = 2'h0, rxe = 2'h0, ckoe = 2'h0, ck = 2'h0;
  logic [5:0] pins, pout, poe, ext_en = 6'h00, ext_val = 6'h00;
  logic [5:0] sio; // Receive 0/1, clock 0/1, interrupt 4/5 outputs
  int err_total = 0, check_count = 0;
  sbp_row_s rows [5] = '{
    '{16'hff62, 8'hff, 8'h3f}, '{16'hff76, 8'h2a, 8'h2a}, '{16'hfeb2, 8'h3f, 8'h00},
    '{16'hff52, 8'h15, 8'h3f}, '{16'h1234, 8'h55, 8'h00}};

  // ----------------------------------------------------------------
  // Clock, design and pin model
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  sbp_port dut (.ref_clk_in(clk), .sys_rst_in(rst), .manual_rst_in(mrst), .hw_standby_in(hws),
    .sw_standby_in(sws), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .serial_init_in(sinit), .serial0_transmit_en_in(txe[0]),
    .serial0_transmit_in(tx[0]), .serial0_receive_enable_in(rxe[0]), .serial0_receive_out(sio[0]),
    .serial0_clock_oe_in(ckoe[0]), .serial0_clock_in(ck[0]), .serial0_clock_out(sio[2]),
    .serial1_transmit_en_in(txe[1]), .serial1_transmit_in(tx[1]), .serial1_receive_enable_in(rxe[1]),
    .serial1_receive_out(sio[1]), .serial1_clock_oe_in(ckoe[1]), .serial1_clock_in(ck[1]),
    .serial1_clock_out(sio[3]), .ext_interrupt_4_out(sio[4]), .ext_interrupt_5_out(sio[5]), .pin_in(pins),
    .pin_out(pout), .pin_oe_out(poe));
  sbp_pin_model pm (.pin_out_in(pout), .pin_oe_in(poe), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .level_out(pins));

  // ----------------------------------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Write strobe stands for one cycle; callers always sit at a rising edge
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  // Strobe rises at once so a read can follow a write with no gap
  // Read data stand only in the cycle after the strobe, taken at its closing edge
  task automatic rreg(input logic [15:0] a, output logic [7:0] d);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog sized well past the expected run of about eighty cycles
  initial begin
    #100000;
    err_total++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] v;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rreg(16'hff62, v);
    chk(v, 8'h00);
    foreach (rows[i]) begin
      wreg(rows[i].a, rows[i].w);
      rreg(rows[i].a, v);
      chk(v, rows[i].e);
    end
    // Data 3f, open-drain 2a: highs on 1,3,5 are released, others push-pull
    repeat (3) @(posedge clk);
    chk({2'h0, poe}, 8'h15);
    chk({2'h0, pout & poe}, 8'h15);
    chk({2'h0, sio}, 8'h3f);
    // Mixed direction: bits 3..0 from data, bits 5..4 from outside pins
    ext_en <= 6'h3f;
    ext_val <= 6'h2d;
    wreg(16'hfeb2, 8'h0f);
    repeat (6) @(posedge clk);
    rreg(16'hff52, v);
    chk(v, 8'h2f);
    chk({2'h0, sio}, 8'h2b);
    // Manual reset freezes the readback view and refuses writes
    mrst <= 1'h1;
    ext_val <= 6'h00;
    wreg(16'hff62, 8'h00);
    repeat (6) @(posedge clk);
    rreg(16'hff52, v);
    chk(v, 8'h2f);
    mrst <= 1'h0;
    // One edge lets the readback view catch up with the pins again
    @(posedge clk);
    rreg(16'hff52, v);
    chk(v, 8'h0f);
    // Software standby refuses writes as well
    sws <= 1'h1;
    wreg(16'hff76, 8'h00);
    sws <= 1'h0;
    rreg(16'hff62, v);
    chk(v, 8'h3f);
    rreg(16'hff76, v);
    chk(v, 8'h2a);
    // Serial active: receive pins forced to input, transmit pins and clock 0 pin driven
    wreg(16'hfeb2, 8'h3f);
    wreg(16'hff76, 8'h00);
    sinit <= 1'h0;
    rxe <= 2'h3;
    txe <= 2'h3;
    tx <= 2'h2;
    ckoe <= 2'h1;
    repeat (3) @(posedge clk);
    chk({6'h0, poe[3:2]}, 8'h00);
    chk({6'h0, poe[1:0] & {pout[1], ~pout[0]}}, 8'h03);
    chk({6'h0, poe[4], pout[4]}, 8'h02);
    // Initialising serial hands every pin back to port registers
    sinit <= 1'h1;
    repeat (3) @(posedge clk);
    chk({2'h0, poe}, 8'h3f);
    chk({2'h0, pout}, 8'h3f);
    // Hardware standby clears direction, data and open-drain
    hws <= 1'h1;
    repeat (2) @(posedge clk);
    hws <= 1'h0;
    rreg(16'hff62, v);
    chk(v, 8'h00);
    repeat (3) @(posedge clk);
    chk({2'h0, poe}, 8'h00);
    // Power-on reset mid-run clears open-drain after a write that landed
    wreg(16'hff76, 8'h3f);
    rreg(16'hff76, v);
    chk(v, 8'h3f);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rreg(16'hff76, v);
    chk(v, 8'h00);
    summarize();
  end
endmodule // tb

`default_nettype wire
